// >>> rec_enable.sv
`timescale 1ns/1ns
module rec_enable (
    input wire logic [2:0] slot,
    input wire logic [1:0] sel,
    input wire logic rail_present,
    input wire logic at_0,
    input wire logic at_25,
    input wire logic at_50,
    input wire logic at_100,
    input wire logic control_input_zero,
    input wire logic control_input_one,
    output logic enable
);
    logic soft_en;
    assign soft_en = (sel == rec_pkg::SEL_ON)
        | ((sel == rec_pkg::SEL_IN0) & control_input_zero)
        | ((sel == rec_pkg::SEL_IN1) & control_input_one);
    always_comb begin
        case (slot)
            rec_pkg::SLOT_ALWAYS: enable = rail_present;
            rec_pkg::SLOT_AT_0: enable = at_0;
            rec_pkg::SLOT_AT_25: enable = at_25;
            rec_pkg::SLOT_AT_50: enable = at_50;
            rec_pkg::SLOT_SOFT: enable = at_100 & soft_en;
            default: enable = 1'b0;
        endcase
    end
endmodule

// >>> rec_far.sv
`timescale 1ns/1ns
module rec_far (
    input wire logic sys_clk,
    output logic rail_present,
    output logic hard_reset,
    output logic step_two_enabled,
    output logic control_input_zero,
    output logic control_input_one,
    output logic [4:0] lin_one_vcode_in
);
    initial begin
        {rail_present, hard_reset, step_two_enabled} = 3'h0;
        {control_input_zero, control_input_one} = 2'h0;
        lin_one_vcode_in = 5'h15;
    end
    // Board levels move just after an edge
    task pins(input logic [4:0] v);
        @(posedge sys_clk);
        {rail_present, hard_reset, step_two_enabled} <= v[4:2];
        {control_input_zero, control_input_one} <= v[1:0];
    endtask
endmodule

// >>> rec_pkg.sv
// Behaviour
// - The step-down two voltage code is six bits at 0x10 (1.5V base, 50mV steps) and is applied only while that regulator is off.
// - The linear one configuration at 0x12 is read/write in bits 3:0; bit 4 reads zero and the boot-slot field is read-only.
// - The three-bit boot-slot field is read-only, and codes 000, 101 and 110 keep the regulator off.
// - Boot-slot 001 keeps the regulator on whenever the battery or system rail is present.
// - Boot-slots 010, 011 and 100 turn the regulator on at 0%, 25% and 50% of the power-up delay.
// - Boot-slot 111 hands control to the enable selector once the power-up delay has fully elapsed.
// - The enable selector is ignored unless the boot-slot is 111.
// - Selector 00 turns the regulator off, with discharge in hard reset or when the policy bit is 1, and selector 01 turns it on.
// - Selector 10 turns the regulator on only while control input zero is high.
// - Selector 11 turns the regulator on only while control input one is high.
// - Discharge is active in hard reset, and also while the effective enable is low when the policy bit is 1.
// - Switch mode 1 runs the regulator as a load switch and mode 0 as a normal regulator.
// - The switch mode is latched internally and a new value takes effect only while the regulator is off.
// - The linear one voltage code is a five-bit read-only field at 0x13.
package rec_pkg;
    localparam logic [7:0] STEP_TWO_VCODE_ADDR = 8'h10;
    localparam logic [7:0] LIN_ONE_CFG_ADDR = 8'h12;
    localparam logic [7:0] LIN_ONE_VCODE_ADDR = 8'h13;
    localparam int SLOT_LSB = 5;
    localparam int DSC_BIT = 3;
    localparam int SEL_LSB = 1;
    localparam int MODE_BIT = 0;
    localparam logic [2:0] SLOT_OFF = 3'h0;
    localparam logic [2:0] SLOT_ALWAYS = 3'h1;
    localparam logic [2:0] SLOT_AT_0 = 3'h2;
    localparam logic [2:0] SLOT_AT_25 = 3'h3;
    localparam logic [2:0] SLOT_AT_50 = 3'h4;
    localparam logic [2:0] SLOT_SOFT = 3'h7;
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_ON = 2'h1;
    localparam logic [1:0] SEL_IN0 = 2'h2;
    localparam logic [1:0] SEL_IN1 = 2'h3;
    localparam logic [5:0] STEP_TWO_VCODE_RESET = 6'h00;
    localparam logic [3:0] CFG_LOW_RESET = 4'h0;
    localparam int BOOT_DELAY_US = 100;
    localparam int CLK_MHZ = 10;
    localparam int BOOT_DELAY_CYCLES = BOOT_DELAY_US * CLK_MHZ;
endpackage

// >>> rec_regs.sv
`timescale 1ns/1ns
module rec_regs #(
    parameter int BOOT_DELAY_CYCLES = rec_pkg::BOOT_DELAY_CYCLES,
    parameter logic [2:0] BOOT_SLOT = rec_pkg::SLOT_SOFT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] lin_one_vcode_in,
    input wire logic rail_present,
    input wire logic hard_reset,
    input wire logic step_two_enabled,
    input wire logic control_input_zero,
    input wire logic control_input_one,
    output logic lin_one_enable,
    output logic lin_one_discharge,
    output logic lin_one_switch_active,
    output logic [5:0] step_two_vcode_active
);
    localparam int CW = $clog2(BOOT_DELAY_CYCLES + 1);
    localparam logic [CW-1:0] FULL = CW'(BOOT_DELAY_CYCLES);
    localparam logic [CW-1:0] QUARTER = CW'(BOOT_DELAY_CYCLES / 4);
    localparam logic [CW-1:0] HALF = CW'(BOOT_DELAY_CYCLES / 2);

    logic [5:0] step_two_vcode_reg;
    logic [3:0] cfg_low_reg;
    logic [CW-1:0] boot_cnt_reg;
    logic [7:0] rdata_reg;
    logic enable_reg;
    logic discharge_reg;
    logic switch_reg;
    logic [5:0] vcode_active_reg;
    logic [7:0] rdata_next;
    logic en_now;
    logic wr_vcode;
    logic wr_cfg;
    logic at_0;
    logic at_25;
    logic at_50;
    logic at_100;
    logic [1:0] sel;

    assign wr_vcode = clk_en & reg_write
        & (reg_addr == rec_pkg::STEP_TWO_VCODE_ADDR);
    assign wr_cfg = clk_en & reg_write
        & (reg_addr == rec_pkg::LIN_ONE_CFG_ADDR);
    assign sel = cfg_low_reg[rec_pkg::SEL_LSB +: 2];
    assign at_0 = rail_present;
    assign at_25 = rail_present & (boot_cnt_reg >= QUARTER);
    assign at_50 = rail_present & (boot_cnt_reg >= HALF);
    assign at_100 = rail_present & (boot_cnt_reg >= FULL);

    // Read mux; unmapped and unused bits give zero
    assign rdata_next =
        (reg_addr == rec_pkg::STEP_TWO_VCODE_ADDR) ?
            {2'b00, step_two_vcode_reg} :
        (reg_addr == rec_pkg::LIN_ONE_CFG_ADDR) ?
            {BOOT_SLOT, 1'b0, cfg_low_reg} :
        (reg_addr == rec_pkg::LIN_ONE_VCODE_ADDR) ?
            {3'b000, lin_one_vcode_in} :
        8'h00;

    rec_enable u_enable (
        .slot(BOOT_SLOT),
        .sel(sel),
        .rail_present(rail_present),
        .at_0(at_0),
        .at_25(at_25),
        .at_50(at_50),
        .at_100(at_100),
        .control_input_zero(control_input_zero),
        .control_input_one(control_input_one),
        .enable(en_now)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            step_two_vcode_reg <= rec_pkg::STEP_TWO_VCODE_RESET;
            cfg_low_reg <= rec_pkg::CFG_LOW_RESET;
        end else begin
            if (wr_vcode) begin
                step_two_vcode_reg <= reg_wdata[5:0];
            end
            if (wr_cfg) begin
                cfg_low_reg <= reg_wdata[3:0];
            end
        end
    end

    // Power-up delay timer, restarts when the rail is lost
    always_ff @(posedge sys_clk) begin
        if (rst || !rail_present) begin
            boot_cnt_reg <= '0;
        end else if (clk_en && boot_cnt_reg != FULL) begin
            boot_cnt_reg <= boot_cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            enable_reg <= 1'b0;
            discharge_reg <= 1'b0;
            switch_reg <= 1'b0;
            vcode_active_reg <= rec_pkg::STEP_TWO_VCODE_RESET;
        end else if (clk_en) begin
            if (reg_read) begin
                rdata_reg <= rdata_next;
            end
            enable_reg <= en_now;
            discharge_reg <= hard_reset
                | (cfg_low_reg[rec_pkg::DSC_BIT] & !en_now);
            if (!en_now) begin
                switch_reg <= cfg_low_reg[rec_pkg::MODE_BIT];
            end
            if (!step_two_enabled) begin
                vcode_active_reg <= step_two_vcode_reg;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign lin_one_enable = enable_reg;
    assign lin_one_discharge = discharge_reg;
    assign lin_one_switch_active = switch_reg;
    assign step_two_vcode_active = vcode_active_reg;

    chk_switch_held: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && $past(clk_en) && enable_reg && $past(en_now)
            |-> $stable(switch_reg))
        else $error("switch mode changed while enabled");
    chk_vcode_held: assert property (
        @(posedge sys_clk) disable iff (rst)
        $past(step_two_enabled) && $past(clk_en) |-> $stable(vcode_active_reg))
        else $error("voltage code changed while enabled");
    chk_disch_policy: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && hard_reset |=> !clk_en || discharge_reg)
        else $error("no discharge in hard reset");
    chk_slot_gate: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT != rec_pkg::SLOT_SOFT
            && BOOT_SLOT != rec_pkg::SLOT_ALWAYS && !rail_present
            |=> !clk_en || !enable_reg)
        else $error("enabled without rail");
    chk_sel_in0: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT == rec_pkg::SLOT_SOFT && at_100
            && sel == rec_pkg::SEL_IN0
            |=> !clk_en || enable_reg == $past(control_input_zero))
        else $error("selector 10 wrong");
    chk_sel_in1: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT == rec_pkg::SLOT_SOFT && at_100
            && sel == rec_pkg::SEL_IN1
            |=> !clk_en || enable_reg == $past(control_input_one))
        else $error("selector 11 wrong");
    chk_sel_off: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && sel == rec_pkg::SEL_OFF && BOOT_SLOT == rec_pkg::SLOT_SOFT
            |=> !clk_en || !enable_reg)
        else $error("selector 00 enabled");
    chk_read_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_read && reg_addr == rec_pkg::STEP_TWO_VCODE_ADDR
            |=> reg_rdata[7:6] == 2'b00)
        else $error("upper bits nonzero");

    chk_always_rail: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT == rec_pkg::SLOT_ALWAYS
            |=> !clk_en
            || enable_reg == $past(rail_present))
        else $error("always-on slot does not follow rail");

    chk_slot_off: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && (BOOT_SLOT == rec_pkg::SLOT_OFF
            || BOOT_SLOT == 3'h5 || BOOT_SLOT == 3'h6)
            |=> !clk_en || !enable_reg)
        else $error("disabled slot enabled");

    chk_quarter_gate: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT == rec_pkg::SLOT_AT_25
            && !at_25
            |=> !clk_en || !enable_reg)
        else $error("quarter slot enabled early");

    chk_half_gate: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && BOOT_SLOT == rec_pkg::SLOT_AT_50
            && !at_50
            |=> !clk_en || !enable_reg)
        else $error("half slot enabled early");

    chk_cfg_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_read
            && reg_addr == rec_pkg::LIN_ONE_CFG_ADDR
            |=> reg_rdata[7:5] == BOOT_SLOT && !reg_rdata[4])
        else $error("config read slot field wrong");

    chk_vcode1_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && reg_read
            && reg_addr == rec_pkg::LIN_ONE_VCODE_ADDR
            |=> reg_rdata == {3'b000, $past(lin_one_vcode_in)})
        else $error("voltage code read wrong");

    chk_mode_apply: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && !en_now
            |=> lin_one_switch_active
            == $past(cfg_low_reg[rec_pkg::MODE_BIT]))
        else $error("switch mode not applied while off");

    chk_step_apply: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && !step_two_enabled
            |=> step_two_vcode_active
            == $past(step_two_vcode_reg))
        else $error("step-down code not applied while off");
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic sys_clk, rst, reg_write, reg_read, clk_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic rail_present, hard_reset, step_two_enabled, e;
    logic control_input_zero, control_input_one;
    logic [4:0] lin_one_vcode_in;
    logic lin_one_enable, lin_one_discharge, lin_one_switch_active;
    logic [5:0] step_two_vcode_active;
    int n_errors = 0;
    int check_count = 0;
    rec_far i_far (.sys_clk(sys_clk), .rail_present(rail_present),
        .hard_reset(hard_reset), .step_two_enabled(step_two_enabled),
        .control_input_zero(control_input_zero),
        .control_input_one(control_input_one),
        .lin_one_vcode_in(lin_one_vcode_in));
    rec_regs #(.BOOT_DELAY_CYCLES(8)) i_dut (.sys_clk(sys_clk), .rst(rst),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .lin_one_vcode_in(lin_one_vcode_in), .rail_present(rail_present),
        .hard_reset(hard_reset), .step_two_enabled(step_two_enabled),
        .control_input_zero(control_input_zero),
        .control_input_one(control_input_one),
        .lin_one_enable(lin_one_enable),
        .lin_one_discharge(lin_one_discharge),
        .lin_one_switch_active(lin_one_switch_active),
        .step_two_vcode_active(step_two_vcode_active));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task chk(input string n, input logic [7:0] x, input logic [7:0] s);
        check_count++;
        if (s !== x) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        rd = reg_rdata;
    endtask
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task summarize;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        summarize;
    end
    initial begin
        {rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'h4, 16'h0000};
        clk_en = 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        i_far.pins(5'b10100);
        wr(8'h12, 8'h02);
        settle(2);
        chk("early_en", 8'h00, {7'h0, lin_one_enable});
        settle(12);
        chk("late_en", 8'h01, {7'h0, lin_one_enable});
        wr(8'h10, 8'hFF);
        rdr(8'h10);
        chk("vcode2_rd", 8'h3F, rd);
        chk("vcode2_held", 8'h00, {2'h0, step_two_vcode_active});
        i_far.pins(5'b10000);
        settle(3);
        chk("vcode2_app", 8'h3F, {2'h0, step_two_vcode_active});
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h10, 8'h01);
        clk_en <= 1'b1;
        rdr(8'h10);
        chk("frozen_wr", 8'h3F, rd);
        wr(8'h13, 8'h00);
        rdr(8'h13);
        chk("vcode1_rd", 8'h15, rd);
        wr(8'h12, 8'hFF);
        rdr(8'h12);
        chk("cfg_rd", 8'hEF, rd);
        for (int i = 0; i < 16; i++) begin
            i_far.pins({3'b100, i[1:0]});
            wr(8'h12, {4'h0, 1'b1, i[3:2], 1'b0});
            settle(2);
            e = (i[3:2] == 1) | (i[3:2] == 2 & i[1]) | (i[3:2] == 3 & i[0]);
            chk("sel_en", {7'h0, e}, {7'h0, lin_one_enable});
            chk("dsc_pol", {7'h0, !e}, {7'h0, lin_one_discharge});
        end
        wr(8'h12, 8'h02);
        wr(8'h12, 8'h03);
        settle(3);
        chk("mode_held", 8'h00, {7'h0, lin_one_switch_active});
        wr(8'h12, 8'h01);
        settle(3);
        chk("mode_app", 8'h01, {7'h0, lin_one_switch_active});
        chk("no_dsc", 8'h00, {7'h0, lin_one_discharge});
        i_far.pins(5'b11000);
        settle(2);
        chk("hard_dsc", 8'h01, {7'h0, lin_one_discharge});
        rdr(8'h55);
        chk("unmapped", 8'h00, rd);
        summarize;
    end
endmodule
